// file: logic/ldp_pkg.sv
// Purpose: Shared constants and types for the laser drive and fault control block
// Assumes: 200 MHz core clock, seven-bit serial register addresses
// Notes:   Timing figures are kept in their own units and converted to cycles here
package ldp_pkg;

    localparam int CLK_MHZ = 200;

    // Register map, serial port addresses
    localparam logic [6:0] REG_CTRL_PRI = 7'h1A;
    localparam logic [6:0] REG_CUR_SET  = 7'h1C;
    localparam logic [6:0] REG_CUR_INV  = 7'h1D;
    localparam logic [6:0] REG_CTRL_SEC = 7'h1F;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // Field layout of the control registers
    localparam int RANGE_MSB = 7;
    localparam int RANGE_LSB = 6;
    localparam int CAL_MSB   = 3;
    localparam int CAL_LSB   = 1;
    localparam logic [2:0] CAL_ENABLE = 3'h5;
    localparam logic [1:0] RANGE_LOW  = 2'h1;
    localparam logic [7:0] CUR_MIN    = 8'h00;

    // Serial frame: address byte with write flag, then data byte
    localparam int         SPI_WRITE_BIT = 7;
    localparam logic [4:0] SPI_ADDR_DONE = 5'h08;
    localparam logic [4:0] SPI_DATA_DONE = 5'h10;

    // Timing
    localparam int SELFTEST_PERIOD_US  = 1000;
    localparam int SELFTEST_PERIOD_CYC = SELFTEST_PERIOD_US * CLK_MHZ;
    localparam int SELFTEST_SETTLE_NS  = 500;
    localparam int SELFTEST_SETTLE_CYC = (SELFTEST_SETTLE_NS * CLK_MHZ + 999) / 1000;
    // Ground sense is ignored this many cycles after a self-test while its path drains
    localparam int SELFTEST_RELEASE_CYC = 8;
    localparam int PULSE_PERIOD_NS     = 2000;
    localparam int PULSE_PERIOD_CYC    = (PULSE_PERIOD_NS * CLK_MHZ) / 1000;
    localparam int PULSE_WIDTH_NS      = 500;
    localparam int PULSE_WIDTH_CYC     = (PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic { LDP_RUN, LDP_TEST } ldp_state_t;

    typedef struct packed {
        logic       on;
        logic       cw;
        logic [1:0] range;
        logic [7:0] current;
    } ldp_drive_t;

endpackage

// file: logic/ldp_laser_ctrl.sv
// Purpose: Laser range/current registers, pulsed or continuous drive, single fault supervision
// Assumes: Serial pins and fault comparators are asynchronous and are synchronised here
// Notes:   A latched fault holds the laser off until the next reset
`timescale 1ns/1ps
`default_nettype none

// Operation
// - With calibration mode enabled in primary bits 3:1 the laser is driven continuously except during each self-test.
// - The supply disable output is low in normal operation and high on a drive pin fault.
// - A ground path on the drive pin clears the drive on bit, keeping the current setting, and raises supply disable.
// - The detector is self-tested periodically; a pin held at supply is reported as a fault.
// - Outside calibration mode the laser is driven in pulses.
module ldp_laser_ctrl
    import ldp_pkg::*;
#(
    parameter int SELFTEST_PERIOD = SELFTEST_PERIOD_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       spi_ncs_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_mosi,
    output var  logic       spi_miso,
    output var  logic       spi_miso_oe,
    input  wire logic       drive_pin_gnd_sense,
    input  wire logic       drive_pin_supply_sense,
    output var  ldp_drive_t laser_drive,
    output var  logic       laser_supply_disable_n,
    output var  logic       selftest_ground_en,
    output var  logic       laser_fault
);

    logic [2:0] ncs_s_q, sclk_s_q;
    logic [1:0] mosi_s_q, gnd_s_q, sup_s_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] rx_q, tx_q;
    logic [6:0] addr_q;
    logic       write_q;
    logic [7:0] ctrl_pri_q, cur_set_q, cur_inv_q, ctrl_sec_q;
    ldp_state_t state_q;
    logic [31:0] timer_q;
    logic [15:0] pulse_cnt_q;
    logic        fault_q;
    logic        sclk_rise, sclk_fall, frame_on;
    logic        cal_on, cur_ok, range_ok, testing;
    logic [3:0]  release_q;
    logic        gnd_armed;
    logic [7:0]  rx_next;

    function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] p,
                                            input logic [7:0] s, input logic [7:0] i,
                                            input logic [7:0] c);
        if (a == REG_CTRL_PRI) begin
            return p;
        end else if (a == REG_CUR_SET) begin
            return s;
        end else if (a == REG_CUR_INV) begin
            return i;
        end else if (a == REG_CTRL_SEC) begin
            return c;
        end else begin
            return 8'h00;
        end
    endfunction

    // Two-flop synchronisers; the third serial stage feeds edge detection only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ncs_s_q  <= 3'h7;
            sclk_s_q <= 3'h0;
            mosi_s_q <= 2'h0;
            gnd_s_q  <= 2'h0;
            sup_s_q  <= 2'h0;
        end else begin
            ncs_s_q  <= {ncs_s_q[1:0], spi_ncs_n};
            sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
            mosi_s_q <= {mosi_s_q[0], spi_mosi};
            gnd_s_q  <= {gnd_s_q[0], drive_pin_gnd_sense};
            sup_s_q  <= {sup_s_q[0], drive_pin_supply_sense};
        end
    end

    assign frame_on  = !ncs_s_q[1];
    assign sclk_rise = frame_on && sclk_s_q[1] && !sclk_s_q[2];
    assign sclk_fall = frame_on && !sclk_s_q[1] && sclk_s_q[2];
    assign rx_next   = {rx_q[6:0], mosi_s_q[1]};

    // Serial frame: shift in on rising edges, capture address after 8 bits
    always_ff @(posedge clk) begin
        if (!reset_n || !frame_on) begin
            bit_cnt_q <= 5'h00;
            rx_q      <= 8'h00;
            addr_q    <= 7'h00;
            write_q   <= 1'b0;
        end else if (sclk_rise) begin
            rx_q      <= rx_next;
            bit_cnt_q <= (bit_cnt_q == SPI_DATA_DONE) ? bit_cnt_q : bit_cnt_q + 5'h01;
            if (bit_cnt_q == SPI_ADDR_DONE - 5'h01) begin
                addr_q  <= rx_next[6:0];
                write_q <= rx_next[SPI_WRITE_BIT];
            end
        end
    end

    // Register writes on the sixteenth rising edge of a write frame
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_pri_q <= REG_RESET;
            cur_set_q  <= REG_RESET;
            cur_inv_q  <= REG_RESET;
            ctrl_sec_q <= REG_RESET;
        end else if (sclk_rise && write_q && bit_cnt_q == SPI_DATA_DONE - 5'h01) begin
            if (addr_q == REG_CTRL_PRI) begin
                ctrl_pri_q <= rx_next;
            end else if (addr_q == REG_CUR_SET) begin
                cur_set_q <= rx_next;
            end else if (addr_q == REG_CUR_INV) begin
                cur_inv_q <= rx_next;
            end else if (addr_q == REG_CTRL_SEC) begin
                ctrl_sec_q <= rx_next;
            end
        end
    end

    // Read data leaves MSB first on falling edges after the address byte
    always_ff @(posedge clk) begin
        if (!reset_n || !frame_on) begin
            tx_q        <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            if (sclk_rise && bit_cnt_q == SPI_ADDR_DONE - 5'h01) begin
                tx_q        <= reg_read(rx_next[6:0], ctrl_pri_q, cur_set_q, cur_inv_q,
                                        ctrl_sec_q);
                spi_miso_oe <= !rx_next[SPI_WRITE_BIT];
            end else if (sclk_fall && !write_q && bit_cnt_q >= SPI_ADDR_DONE) begin
                spi_miso <= tx_q[7];
                tx_q     <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign cal_on   = ctrl_pri_q[CAL_MSB:CAL_LSB] == CAL_ENABLE;
    assign cur_ok   = cur_set_q == ~cur_inv_q;
    assign range_ok = ctrl_pri_q[RANGE_MSB:RANGE_LSB] == ~ctrl_sec_q[RANGE_MSB:RANGE_LSB];
    assign testing  = state_q == LDP_TEST;

    // Periodic self-test of the fault detector with the supply cut
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= LDP_RUN;
            timer_q <= 32'h0;
        end else begin
            case (state_q)
                LDP_RUN: begin
                    if (timer_q == 32'(SELFTEST_PERIOD - 1)) begin
                        state_q <= LDP_TEST;
                        timer_q <= 32'h0;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                default: begin
                    if (timer_q == 32'(SELFTEST_SETTLE_CYC - 1)) begin
                        state_q <= LDP_RUN;
                        timer_q <= 32'h0;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
            endcase
        end
    end

    // The test's own ground path is still seen through the pin and synchroniser for a
    // few cycles after the test ends; without this blanking it would latch a fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            release_q <= 4'h0;
        end else if (testing) begin
            release_q <= 4'(SELFTEST_RELEASE_CYC);
        end else if (release_q != 4'h0) begin
            release_q <= release_q - 4'h1;
        end
    end

    assign gnd_armed = !testing && release_q == 4'h0;

    // Fault latch: ground path in run, or pin not pulled low during the test
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_q <= 1'b0;
        end else if (gnd_armed && gnd_s_q[1]) begin
            fault_q <= 1'b1;
        end else if (testing && timer_q == 32'(SELFTEST_SETTLE_CYC - 1)
                     && (!gnd_s_q[1] || sup_s_q[1])) begin
            fault_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || pulse_cnt_q == 16'(PULSE_PERIOD_CYC - 1)) begin
            pulse_cnt_q <= 16'h0;
        end else begin
            pulse_cnt_q <= pulse_cnt_q + 16'h1;
        end
    end

    // Drive outputs, all registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            laser_drive            <= '{on: 1'b0, cw: 1'b0, range: RANGE_LOW, current: CUR_MIN};
            laser_supply_disable_n <= 1'b0;
            selftest_ground_en     <= 1'b0;
            laser_fault            <= 1'b0;
        end else begin
            laser_drive.cw      <= cal_on;
            laser_drive.on      <= !fault_q && !testing
                                   && (cal_on || pulse_cnt_q < 16'(PULSE_WIDTH_CYC));
            laser_drive.current <= cur_ok ? cur_set_q : CUR_MIN;
            laser_drive.range   <= range_ok ? ctrl_pri_q[RANGE_MSB:RANGE_LSB] : RANGE_LOW;
            laser_supply_disable_n <= fault_q || testing;
            selftest_ground_en     <= testing && !fault_q;
            laser_fault            <= fault_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_cal_cw_drive: assert property (
        cal_on && !fault_q && !testing |=> laser_drive.on && laser_drive.cw)
        else $error("calibration mode did not give continuous drive");
    a_supply_normal: assert property (
        !fault_q && !testing |=> !laser_supply_disable_n)
        else $error("supply disable raised in normal operation");
    a_gnd_fault_off: assert property (
        gnd_armed && gnd_s_q[1] |=> ##1 !laser_drive.on && laser_supply_disable_n)
        else $error("ground path did not shut the laser off");
    a_test_supply: assert property (
        $rose(testing) |-> ##1 (laser_supply_disable_n && !laser_drive.on) [*3])
        else $error("self-test ran with laser supply connected");
    a_test_short: assert property (
        testing && timer_q == 32'(SELFTEST_SETTLE_CYC - 1) && sup_s_q[1] |=> fault_q)
        else $error("supply short during self-test not reported");
    a_pulse_off: assert property (
        !cal_on && pulse_cnt_q == 16'(PULSE_WIDTH_CYC) |=> !laser_drive.on)
        else $error("pulsed drive did not turn off");
    a_fault_sticky: assert property (
        fault_q |=> fault_q && !laser_drive.on && laser_supply_disable_n)
        else $error("fault released before reset");
    a_cur_invalid: assert property (
        !cur_ok |=> laser_drive.current == CUR_MIN)
        else $error("invalid current pair not forced to minimum");

    c_cal_mode:   cover property (cal_on && laser_drive.cw);
    c_test_pass:  cover property ($fell(testing) && !fault_q);
    c_gnd_fault:  cover property ($rose(fault_q) && !testing);
    c_reg_write:  cover property (sclk_rise && write_q && bit_cnt_q == SPI_DATA_DONE - 5'h01);

endmodule

`default_nettype wire

// file: dv/ldp_spi_host.sv
// Purpose: Serial host model that programs and reads the laser block
// Assumes: Serial clock idles low, bits go MSB first
// Notes:   Half period in clk cycles is adjustable, four at the least
`timescale 1ns/1ps
`default_nettype none
module ldp_spi_host (
    input  wire logic clk,
    input  wire logic miso,
    output var  logic ncs_n,
    output var  logic sclk,
    output var  logic mosi
);
    int half = 8;
    initial begin
        ncs_n = 1'b1;
        sclk  = 1'b0;
        mosi  = 1'b0;
    end
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        ncs_n <= 1'b0;
        repeat (half) @(posedge clk);
        for (int b = 15; b >= 0; b--) begin
            mosi <= tx[b];
            repeat (half) @(posedge clk);
            sclk <= 1'b1;
            rx = {rx[6:0], miso};
            repeat (half) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4 * half) @(posedge clk);
        ncs_n <= 1'b1;
        // Deselected line must not keep showing the last bit
        mosi  <= ~tx[0];
        repeat (2 * half) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the laser drive and fault block
// Assumes: Short self-test period, host model on the serial port
// Notes:   Drive pin model grounds the pin in self-test unless shorted
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ldp_pkg::*;
    localparam int PER = 300;
    logic       clk, reset_n, gnd_q, sup_q, gnd_fault, sup_short;
    logic       miso, miso_oe, st_en, fault, dis_n, ncs_n, sclk, mosi;
    wire  logic miso_w;
    ldp_drive_t drv;
    int         error_cnt, checked, c;
    logic [6:0] regs [4] = '{REG_CTRL_PRI, REG_CUR_SET, REG_CUR_INV, REG_CTRL_SEC};
    logic [7:0] steps [3] = '{8'h01, 8'h80, 8'hFF};
    ldp_laser_ctrl #(.SELFTEST_PERIOD(PER)) ldp_laser_ctrl_inst (
        .clk(clk), .reset_n(reset_n), .spi_ncs_n(ncs_n), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
        .drive_pin_gnd_sense(gnd_q), .drive_pin_supply_sense(sup_q),
        .laser_drive(drv), .laser_supply_disable_n(dis_n),
        .selftest_ground_en(st_en), .laser_fault(fault));
    ldp_spi_host ldp_spi_host_inst (
        .clk(clk), .miso(miso_w), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi));
    assign miso_w = miso_oe ? miso : 1'bz;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        gnd_q <= (st_en & ~sup_short) | gnd_fault;
        sup_q <= sup_short;
    end
    task automatic test_done();
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        ldp_spi_host_inst.xfer({1'b1, a, d}, r);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        ldp_spi_host_inst.xfer({1'b0, a, 8'h00}, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic setcur(input logic [7:0] k);
        wr(REG_CUR_SET, k);
        wr(REG_CUR_INV, ~k);
    endtask
    task automatic count_on(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            c += int'(drv.on);
        end
    endtask
    task automatic do_reset();
        reset_n   <= 1'b0;
        gnd_fault <= 1'b0;
        sup_short <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        gnd_fault = 1'b0;
        sup_short = 1'b0;
        gnd_q = 1'b0;
        sup_q = 1'b0;
        error_cnt = 0;
        checked = 0;
        do_reset();
        chk({4'h0, drv}, 16'h0100);
        chk(dis_n, 1'b0);
        foreach (regs[i]) rchk(regs[i], 8'h00);
        rchk(7'h3E, 8'h00);
        wr(REG_CTRL_PRI, 8'h4A);
        wr(REG_CTRL_SEC, 8'h80);
        setcur(CUR_MIN);
        rchk(REG_CTRL_PRI, 8'h4A);
        rchk(REG_CUR_INV, 8'hFF);
        chk(drv[10:0], {1'b1, RANGE_LOW, CUR_MIN});
        count_on(1200);
        chk(16'(c >= 700), 16'h0001);
        chk(fault, 1'b0);
        ldp_spi_host_inst.half = 4;
        foreach (steps[i]) begin
            setcur(steps[i]);
            chk(drv.current, steps[i]);
        end
        ldp_spi_host_inst.half = 8;
        wr(REG_CUR_SET, 8'h33);
        chk(drv.current, CUR_MIN);
        wr(REG_CUR_INV, 8'hCC);
        chk(drv.current, 8'h33);
        setcur(CUR_MIN);
        wr(REG_CTRL_PRI, 8'h8A);
        wr(REG_CTRL_SEC, 8'h40);
        chk(drv.range, 2'h2);
        wr(REG_CTRL_SEC, 8'h80);
        chk(drv.range, RANGE_LOW);
        wr(REG_CTRL_PRI, 8'h80);
        chk(drv.cw, 1'b0);
        count_on(1200);
        chk(16'(c > 0 && c <= 310), 16'h0001);
        repeat (PER + 10) if (!st_en) @(posedge clk);
        chk({dis_n, drv.on}, 2'b10);
        repeat (PER) if (st_en) @(posedge clk);
        // Stay clear of the ground-sense blanking that follows each self-test
        repeat (20) @(posedge clk);
        gnd_fault <= 1'b1;
        repeat (2) @(posedge clk);
        gnd_fault <= 1'b0;
        repeat (10) @(posedge clk);
        chk({fault, dis_n, drv.on}, 3'b110);
        repeat (700) @(posedge clk);
        chk({fault, dis_n, drv.on}, 3'b110);
        do_reset();
        chk({fault, dis_n}, 2'b00);
        wr(REG_CTRL_PRI, 8'h4A);
        wr(REG_CTRL_SEC, 8'h80);
        setcur(8'h21);
        chk(drv[10:0], {1'b1, RANGE_LOW, 8'h21});
        sup_short <= 1'b1;
        repeat (PER + 150) @(posedge clk);
        chk({fault, dis_n}, 2'b11);
        test_done();
    end
endmodule
`default_nettype wire
